// ### tbf_pkg.sv
// Package with timing constants, field limits and state codes of the timebase flag block.
package tbf_pkg;
	localparam int unsigned CLK_HZ       = 25_000_000;
	localparam int unsigned TICK_MS      = 5;
	// Cycles per 5 ms half-period of the fastest flag.
	localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned TICK_W       = 17;
	localparam logic [3:0]  HALF_10MS    = 4'h1;
	localparam logic [3:0]  DIV_DECADE   = 4'h9;
	localparam logic [7:0]  DIV_30S      = 8'h3B;
	localparam logic [7:0]  DIV_MS100    = 8'h63;
	localparam logic [5:0]  SEC_MAX      = 6'h3B;
	localparam logic [5:0]  MIN_MAX      = 6'h3B;
	localparam logic [4:0]  HOUR_MAX     = 5'h17;
	localparam logic [5:0]  SEC_HALF     = 6'h1E;
	localparam logic [5:0]  ZERO6        = 6'h00;
	localparam logic [4:0]  ZERO5        = 5'h00;

	typedef enum logic [2:0] {
		TBF_RUN    = 3'b001,
		TBF_PRESET = 3'b010,
		TBF_ERROR  = 3'b100
	} tbf_state_t;
endpackage : tbf_pkg

// ### tbf_tick_if.sv
// Interface carrying the common timebase ticks between the divider and the flag logic.
interface tbf_tick_if;
	logic tick5ms;
	logic tick1s;
	logic [3:0] stage;
	modport src (output tick5ms, output tick1s, output stage);
	modport dst (input tick5ms, input tick1s, input stage);
endinterface : tbf_tick_if

// ### tbf_divider.sv
// Free-running timebase divider producing 5 ms and 1 s ticks and the four flag stages.
module tbf_divider (
	input  wire logic  core_clk,
	input  wire logic  arst_n,
	tbf_tick_if.src    tk
);
	logic [tbf_pkg::TICK_W-1:0] cycCnt;
	logic [3:0]                 d10, d100;
	logic [7:0]                 d30;
	logic [3:0]                 stg;
	logic                       t5;

	assign t5 = (cycCnt == tbf_pkg::TICK_W'(tbf_pkg::TICK_CYCLES - 1));

	// One counter chain feeds every flag so all edges stay phase-aligned.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cycCnt <= '0;
		end else if (t5) begin
			cycCnt <= '0;
		end else begin
			cycCnt <= cycCnt + 1'b1; // R10
		end
	end

	// Cascaded half-period dividers; each stage toggles its flag on wrap.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			d10 <= '0;
			d100 <= '0;
			d30 <= '0;
			stg <= '0;
		end else if (t5) begin
			stg[0] <= ~stg[0]; // R1
			if (d10 == tbf_pkg::DIV_DECADE) begin
				d10 <= '0;
				stg[1] <= ~stg[1]; // R2
				if (d100 == tbf_pkg::DIV_DECADE) begin
					d100 <= '0;
					stg[2] <= ~stg[2]; // R3
					if (d30 == tbf_pkg::DIV_30S) begin
						d30 <= '0;
						stg[3] <= ~stg[3]; // R4
					end else begin
						d30 <= d30 + 1'b1;
					end
				end else begin
					d100 <= d100 + 1'b1;
				end
			end else begin
				d10 <= d10 + 1'b1;
			end
		end
	end

	assign tk.tick5ms = t5;
	assign tk.tick1s  = t5 && stg[2] && (d10 == tbf_pkg::DIV_DECADE)
		&& (d100 == tbf_pkg::DIV_DECADE);
	assign tk.stage   = stg;

	// A 5 ms tick is never followed by another within the next 8 cycles.
	AST_TICK_SPACING: assert property (@(posedge core_clk) disable iff (!arst_n) // R10
		t5 |=> !t5 [*8]) else $error("5 ms ticks too close");
endmodule : tbf_divider

// ### tbf_timebase_flags.sv
// Top of the timebase pulse flags and real-time clock control and status bits.
// Overview of operation
// R1 - Fast flag is a square wave, 10 ms period, 5 ms on and off.
// R2 - Tenth-second flag has 100 ms period, 50 ms on and off.
// R3 - One-second flag has 1 s period, 500 ms on and off.
// R4 - One-minute flag has 1 min period, 30 s on and off.
// R5 - Stop-preset bit halts time counting and loads preset time fields.
// R6 - Display-freeze bit holds the shown time while counting continues.
// R7 - Correction bit rounds seconds toward the nearest whole minute.
// R8 - Clock-installed bit always reads as asserted.
// R9 - Clock-error bit is set when time data are invalid.
// R10 - All flags come from one free-running counter and are read-only.
module tbf_timebase_flags (
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic       clock_stop_preset_bit,
	input  wire logic       display_freeze_bit,
	input  wire logic       thirty_second_correct_bit,
	input  wire logic [5:0] presetSec,
	input  wire logic [5:0] presetMin,
	input  wire logic [4:0] presetHour,
	output logic            pulse_10ms_flag,
	output logic            pulse_100ms_flag,
	output logic            pulse_1s_flag,
	output logic            pulse_1min_flag,
	output logic            clock_installed_bit,
	output logic            clock_error_bit,
	output logic [5:0]      shownSec,
	output logic [5:0]      shownMin,
	output logic [4:0]      shownHour
);
	tbf_tick_if tk ();
	tbf_pkg::tbf_state_t state;
	logic [5:0] sec, min;
	logic [4:0] hour;
	logic       corrPrev;
	logic       corrEdge;
	logic       badTime;

	tbf_divider uDiv (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.tk       (tk)
	);

	//////////////////////////////////////////////////////////////////////////
	// Pulse flags are registered copies of the divider stages; no input can write them.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pulse_10ms_flag <= 1'b0;
			pulse_100ms_flag <= 1'b0;
			pulse_1s_flag <= 1'b0;
			pulse_1min_flag <= 1'b0;
		end else begin
			pulse_10ms_flag <= tk.stage[0]; // R1
			pulse_100ms_flag <= tk.stage[1]; // R2
			pulse_1s_flag <= tk.stage[2]; // R3
			pulse_1min_flag <= tk.stage[3]; // R4
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Validity of the held time fields; any field out of range is an error.
	function automatic logic tbf_bad(input logic [5:0] s, input logic [5:0] m,
		input logic [4:0] h);
		tbf_bad = (s > tbf_pkg::SEC_MAX) || (m > tbf_pkg::MIN_MAX) || (h > tbf_pkg::HOUR_MAX);
	endfunction : tbf_bad

	assign badTime  = tbf_bad(sec, min, hour);
	assign corrEdge = thirty_second_correct_bit && !corrPrev;

	// Correction acts on the rising edge of its bit, so holding it does not repeat.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			corrPrev <= 1'b0;
		end else begin
			corrPrev <= thirty_second_correct_bit;
		end
	end

	// Mode machine: preset while stopped, error on bad data until a preset repairs it.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= tbf_pkg::TBF_RUN;
		end else begin
			case (state)
				tbf_pkg::TBF_RUN: begin
					if (clock_stop_preset_bit) begin
						state <= tbf_pkg::TBF_PRESET;
					end else if (badTime) begin
						state <= tbf_pkg::TBF_ERROR; // R9
					end
				end
				tbf_pkg::TBF_PRESET: begin
					if (!clock_stop_preset_bit) begin
						state <= tbf_pkg::TBF_RUN;
					end
				end
				tbf_pkg::TBF_ERROR: begin
					if (clock_stop_preset_bit) begin
						state <= tbf_pkg::TBF_PRESET;
					end
				end
				default: begin
					state <= tbf_pkg::TBF_RUN;
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Time counting; a bad preset is still loaded so that the error can report it.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sec <= tbf_pkg::ZERO6;
			min <= tbf_pkg::ZERO6;
			hour <= tbf_pkg::ZERO5;
		end else if (state == tbf_pkg::TBF_PRESET) begin
			sec <= presetSec; // R5
			min <= presetMin; // R5
			hour <= presetHour; // R5
		end else if (state == tbf_pkg::TBF_RUN && !clock_stop_preset_bit) begin
			if (corrEdge) begin
				sec <= tbf_pkg::ZERO6; // R7
				if (sec >= tbf_pkg::SEC_HALF) begin
					if (min == tbf_pkg::MIN_MAX) begin
						min <= tbf_pkg::ZERO6;
						hour <= (hour == tbf_pkg::HOUR_MAX) ? tbf_pkg::ZERO5 : hour + 1'b1;
					end else begin
						min <= min + 1'b1; // R7
					end
				end
			end else if (tk.tick1s) begin
				if (sec == tbf_pkg::SEC_MAX) begin
					sec <= tbf_pkg::ZERO6;
					if (min == tbf_pkg::MIN_MAX) begin
						min <= tbf_pkg::ZERO6;
						hour <= (hour == tbf_pkg::HOUR_MAX) ? tbf_pkg::ZERO5 : hour + 1'b1;
					end else begin
						min <= min + 1'b1;
					end
				end else begin
					sec <= sec + 1'b1;
				end
			end
		end
	end

	// Shown time follows the counter unless frozen; counting itself never stops here.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			shownSec <= tbf_pkg::ZERO6;
			shownMin <= tbf_pkg::ZERO6;
			shownHour <= tbf_pkg::ZERO5;
		end else if (!display_freeze_bit) begin
			shownSec <= sec; // R6
			shownMin <= min; // R6
			shownHour <= hour; // R6
		end
	end

	// Status bits: installed is constant on, error mirrors the error state.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			clock_installed_bit <= 1'b1;
			clock_error_bit <= 1'b0;
		end else begin
			clock_installed_bit <= 1'b1; // R8
			clock_error_bit <= (state == tbf_pkg::TBF_ERROR); // R9
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Control and status checks; a preset lands on the edge after the first edge that sees the stop bit.
	sequence seqStopHeld;
		clock_stop_preset_bit [*2];
	endsequence

	// Bad data seen while running; the error bit follows two edges later.
	sequence seqBadRun;
		state == tbf_pkg::TBF_RUN && badTime && !clock_stop_preset_bit;
	endsequence

	AST_PRESET_LOADS: assert property (@(posedge core_clk) disable iff (!arst_n) // R5
		seqStopHeld ##1 clock_stop_preset_bit |=> (sec == $past(presetSec)))
		else $error("preset not loaded");
	AST_FREEZE_HOLDS: assert property (@(posedge core_clk) disable iff (!arst_n) // R6
		display_freeze_bit |=> $stable(shownSec)) else $error("display moved while frozen");
	AST_CORR_ZERO: assert property (@(posedge core_clk) disable iff (!arst_n) // R7
		corrEdge && state == tbf_pkg::TBF_RUN && !clock_stop_preset_bit |=> sec == tbf_pkg::ZERO6)
		else $error("correction did not zero seconds");
	AST_INSTALLED: assert property (@(posedge core_clk) disable iff (!arst_n) // R8
		clock_installed_bit) else $error("installed bit dropped");
	AST_ERROR_SET: assert property (@(posedge core_clk) disable iff (!arst_n) // R9
		seqBadRun |=> ##1 clock_error_bit)
		else $error("error bit not set");
	AST_FAST_FLAG: assert property (@(posedge core_clk) disable iff (!arst_n) // R1
		tk.tick5ms |=> ##1 (pulse_10ms_flag != $past(pulse_10ms_flag)))
		else $error("fast flag did not toggle");
	AST_100_FLAG: assert property (@(posedge core_clk) disable iff (!arst_n) // R2
		$changed(pulse_100ms_flag) |-> $changed(pulse_10ms_flag))
		else $error("100 ms flag off the common edge");
	AST_1S_FLAG: assert property (@(posedge core_clk) disable iff (!arst_n) // R3
		$changed(pulse_1s_flag) |-> $changed(pulse_100ms_flag))
		else $error("1 s flag off the common edge");
	AST_1MIN_FLAG: assert property (@(posedge core_clk) disable iff (!arst_n) // R4
		$changed(pulse_1min_flag) |-> $rose(pulse_1s_flag) || $fell(pulse_1s_flag))
		else $error("1 min flag off the common edge");

	// Refusals and the common tick; these catch guards that a plain run passes over.
	AST_HALT_ON_STOP: assert property (@(posedge core_clk) disable iff (!arst_n) // R5
		state == tbf_pkg::TBF_RUN && clock_stop_preset_bit |=> $stable(sec))
		else $error("time moved while stopped");
	AST_CORR_REFUSED: assert property (@(posedge core_clk) disable iff (!arst_n) // R7
		corrEdge && state == tbf_pkg::TBF_ERROR |=> $stable(sec))
		else $error("correction acted in error state");
	AST_ERROR_STICKS: assert property (@(posedge core_clk) disable iff (!arst_n) // R9
		state == tbf_pkg::TBF_ERROR && !clock_stop_preset_bit |=> state == tbf_pkg::TBF_ERROR)
		else $error("error state left without a preset");
	AST_ERROR_CLEAR: assert property (@(posedge core_clk) disable iff (!arst_n) // R9
		state == tbf_pkg::TBF_PRESET |=> !clock_error_bit)
		else $error("error bit kept after preset");
	AST_STAGE_ON_TICK: assert property (@(posedge core_clk) disable iff (!arst_n) // R10
		$changed(tk.stage) |-> $past(tk.tick5ms))
		else $error("flag stage moved off the common tick");
endmodule : tbf_timebase_flags

// ### tbf_timebase_flags_tb_top.sv
// Self-checking testbench of the timebase flags and real-time clock control bits.
module tbf_timebase_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic       core_clk = 1'b0;
	logic       arst_n = 1'b0;
	logic       clock_stop_preset_bit = 1'b0;
	logic       display_freeze_bit = 1'b0;
	logic       thirty_second_correct_bit = 1'b0;
	logic [5:0] presetSec = 6'h00;
	logic [5:0] presetMin = 6'h00;
	logic [4:0] presetHour = 5'h00;
	logic       pulse_10ms_flag, pulse_100ms_flag, pulse_1s_flag, pulse_1min_flag;
	logic       clock_installed_bit, clock_error_bit;
	logic [5:0] shownSec, shownMin;
	logic [4:0] shownHour;
	int         errors = 0;
	int         checked = 0;
	bit         fastDone = 1'b0;

	tbf_timebase_flags dut (.core_clk(core_clk), .arst_n(arst_n),
		.clock_stop_preset_bit(clock_stop_preset_bit), .display_freeze_bit(display_freeze_bit),
		.thirty_second_correct_bit(thirty_second_correct_bit), .presetSec(presetSec),
		.presetMin(presetMin), .presetHour(presetHour), .pulse_10ms_flag(pulse_10ms_flag),
		.pulse_100ms_flag(pulse_100ms_flag), .pulse_1s_flag(pulse_1s_flag),
		.pulse_1min_flag(pulse_1min_flag), .clock_installed_bit(clock_installed_bit),
		.clock_error_bit(clock_error_bit), .shownSec(shownSec), .shownMin(shownMin),
		.shownHour(shownHour));

	// The 25 MHz core clock.
	always #20 core_clk = ~core_clk;

	////////////////////////////////////////////////////////////////////////////////
	// Inputs move 2 ns after the rising edge so no sampling race is possible.
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask : step

	task automatic check(input string name, input logic [5:0] exp, input logic [5:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// Stop-preset stays held on return, so the caller chooses when time resumes.
	task automatic preset(input logic [5:0] s, input logic [5:0] m, input logic [4:0] h);
		clock_stop_preset_bit = 1'b1;
		presetSec = s;
		presetMin = m;
		presetHour = h;
		step(3);
	endtask : preset

	task automatic pulseCorrect();
		thirty_second_correct_bit = 1'b1;
		step(1);
		thirty_second_correct_bit = 1'b0;
		step(1);
	endtask : pulseCorrect

	// Waits a bounded number of cycles for the shown time, then compares all fields.
	task automatic waitTime(input logic [5:0] s, input logic [5:0] m, input logic [4:0] h);
		for (int i = 0; i < 8 && !(shownSec === s && shownMin === m && shownHour === h); i++)
			step(1);
		check("shownSec", s, shownSec);
		check("shownMin", m, shownMin);
		check("shownHour", {1'b0, h}, {1'b0, shownHour});
	endtask : waitTime

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////////////
	// Counts edges from reset release to the first rise of the fast flag.
	initial begin
		int edges;
		edges = 0;
		@(posedge arst_n);
		while (pulse_10ms_flag !== 1'b1 && edges < 130000) begin
			@(posedge core_clk);
			#1;
			edges++;
		end
		checked++;
		if (edges < 125000 || edges > 125002) begin
			errors++;
			$display("BAD fastRise expected %0d seen %0d", 125001, edges);
		end
		check("slowFlags", 6'h00, {3'h0, pulse_100ms_flag, pulse_1s_flag, pulse_1min_flag});
		$display("test fast flag done");
		fastDone = 1'b1;
	end

	// Watchdog sized 25k cycles above the 125k cycles the fast flag needs.
	initial begin
		#6_000_000;
		errors++;
		conclude();
	end

	// Main sequence of control-bit tests.
	initial begin
		logic [5:0] bs [3];
		logic [5:0] bm [3];
		logic [4:0] bh [3];
		bs = '{6'h3C, 6'h00, 6'h00};
		bm = '{6'h00, 6'h3C, 6'h00};
		bh = '{5'h00, 5'h00, 5'h18};
		step(10);
		check("inReset", 6'h20, {clock_installed_bit, clock_error_bit, pulse_10ms_flag, pulse_100ms_flag, pulse_1s_flag, pulse_1min_flag});
		arst_n = 1'b1;
		step(1);
		preset(6'h2D, 6'h0A, 5'h05);
		waitTime(6'h2D, 6'h0A, 5'h05);
		pulseCorrect();
		waitTime(6'h2D, 6'h0A, 5'h05);
		$display("test preset done");
		// Rounding down, the half-minute boundary and a carry into the hour.
		preset(6'h1D, 6'h0A, 5'h05);
		clock_stop_preset_bit = 1'b0;
		step(2);
		pulseCorrect();
		waitTime(6'h00, 6'h0A, 5'h05);
		preset(6'h1E, 6'h0A, 5'h05);
		clock_stop_preset_bit = 1'b0;
		step(2);
		pulseCorrect();
		waitTime(6'h00, 6'h0B, 5'h05);
		preset(6'h2D, 6'h3B, 5'h05);
		clock_stop_preset_bit = 1'b0;
		step(2);
		pulseCorrect();
		waitTime(6'h00, 6'h00, 5'h06);
		$display("test correction done");
		preset(6'h0C, 6'h22, 5'h07);
		display_freeze_bit = 1'b1;
		step(1);
		preset(6'h14, 6'h28, 5'h08);
		waitTime(6'h0C, 6'h22, 5'h07);
		display_freeze_bit = 1'b0;
		waitTime(6'h14, 6'h28, 5'h08);
		$display("test freeze done");
		// Each invalid field alone must raise the error, and a valid preset must clear it.
		for (int k = 0; k < 3; k++) begin
			preset(bs[k], bm[k], bh[k]);
			clock_stop_preset_bit = 1'b0;
			for (int i = 0; i < 8 && clock_error_bit !== 1'b1; i++)
				step(1);
			check("errorSet", 6'h01, {5'h00, clock_error_bit});
			pulseCorrect();
			waitTime(bs[k], bm[k], bh[k]);
			preset(6'h01, 6'h02, 5'h03);
			clock_stop_preset_bit = 1'b0;
			for (int i = 0; i < 8 && clock_error_bit !== 1'b0; i++)
				step(1);
			check("errorClear", 6'h00, {5'h00, clock_error_bit});
		end
		check("installed", 6'h01, {5'h00, clock_installed_bit});
		$display("test error done");
		wait (fastDone);
		conclude();
	end
endmodule : tbf_timebase_flags_tb_top
